/* inc/sww_params.svh */
// Timing counts, frame length, inhibit keys, register offsets and reset values for the watchdog.
`ifndef SWW_PARAMS_SVH
`define SWW_PARAMS_SVH
`define SWW_CLK_PERIOD_NS 10
`define SWW_TICK_NS 1000000
`define SWW_TICK_CYC (`SWW_TICK_NS / `SWW_CLK_PERIOD_NS)
`define SWW_LONG_OPEN_WINDOW_MS 256
`define SWW_BASE_MS 11'h010
`define SWW_DEF_CODE 3'h4
`define SWW_CODE_MAX 3'h6
`define SWW_FRAME_BITS 5'h10
`define SWW_INH_KEY_A 8'ha5
`define SWW_INH_KEY_B 8'h5a
`define SWW_AW 4
`define SWW_OFF_STATUS 4'h0
`define SWW_OFF_CONFIG 4'h4
`define SWW_OFF_MASK 4'h8
`define SWW_CAUSE_WD 2'h1
`define SWW_FALLBACK_WD 3'h1
`define SWW_MASK_RESET 1'h1
`endif

/* inc/sww_pkg.sv */
// Types shared by the watchdog: modes, frame selections, frame layout and state.
package sww_pkg;
   typedef enum logic [2:0] {
      SWW_M_INIT = 3'h0,
      SWW_M_NORMAL = 3'h1,
      SWW_M_STOP = 3'h2,
      SWW_M_FLASH = 3'h3,
      SWW_M_SLEEP = 3'h4,
      SWW_M_FAILSAFE = 3'h5,
      SWW_M_RESTART = 3'h6
   } sww_mode_t;
   typedef enum logic [2:0] {
      SWW_S_NORMAL = 3'h0,
      SWW_S_STOP = 3'h1,
      SWW_S_FLASH = 3'h2,
      SWW_S_CONFIG = 3'h3,
      SWW_S_INHIBIT = 3'h4,
      SWW_S_READONLY = 3'h7
   } sww_sel_t;
   typedef enum logic [2:0] {
      SWW_OFF = 3'h0,
      SWW_IDLE = 3'h1,
      SWW_RUN = 3'h2,
      SWW_INHIB = 3'h3,
      SWW_FAIL = 3'h4
   } sww_state_t;
   typedef struct packed {
      logic window;
      logic [2:0] code;
   } sww_cfg_t;
   typedef struct packed {
      logic [2:0] sel;
      logic refresh;
      sww_cfg_t cfg;
      logic [7:0] key;
   } sww_frame_t;
endpackage : sww_pkg

/* design/sww_watchdog.sv */
// Time-out and window watchdog fed by serial frames, with a small register port.
`timescale 1ns/1ps
`include "sww_params.svh"
// How it works
// - default is 256 ms time-out mode
// - refresh bit resets to zero
// - after watchdog reset, start long open window
// - development mode reports failure, no reset
// - init mode: configurable, watchdog inactive
// - stop and flash keep configuration fixed
// - sleep, fail-safe, restart discard configuration
// - trigger is refresh change at select rise
// - time-out mode: any toggle restarts period
// - period from timing field, 16-1024 ms
// - refresh accepted from several frame selections
// - failure drives reset low, restart/fail-safe
// - configs 1/3 restart with default, status bits
// - window mode: closed half then open half
// - good trigger starts next closed window immediately
// - new setting rides a valid trigger
// - invalid setting kept out, flag raised
// - protected inhibit only in stop or flash
// - resume from inhibit: old settings, fresh timer
// - cyclic wake unacknowledged forces restart
module sww_watchdog #(
   parameter int TICK_CYC = `SWW_TICK_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic serial_select_low,
   input wire logic serial_clk,
   input wire logic serial_data_in,
   input wire logic sw_dev_pin,
   input wire sww_pkg::sww_mode_t sbc_mode,
   input wire logic cfg_restart,
   input wire logic cyclic_wake,
   input wire logic wake_status_read,
   input wire logic [`SWW_AW-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic reset_output_pin_n,
   output logic wd_fail_pulse,
   output logic fail_to_restart,
   output logic int_pulse
);
   import sww_pkg::*;

   if (TICK_CYC < 2) begin : g_bad_tick
      $error("TICK_CYC must be at least 2");
   end

   localparam sww_cfg_t CFG_DEF = '{window: 1'b0, code: `SWW_DEF_CODE};

   // Pin synchronisers; stage one feeds only stage two.
   logic [2:0] csn_s1_q, csn_s2_q;
   logic csn_prev_q, sclk_prev_q, sw_dev_q;
   always_ff @(posedge mclk) begin
      if (rst) begin
         csn_s1_q <= 3'h4;
         csn_s2_q <= 3'h4;
      end else begin
         csn_s1_q <= {serial_select_low, serial_clk, serial_data_in};
         csn_s2_q <= csn_s1_q;
      end
   end
   wire csn_s = csn_s2_q[2];
   wire sclk_s = csn_s2_q[1];
   wire sdi_s = csn_s2_q[0];
   wire sw_dev_s = sw_dev_q;
   logic sw_dev_s1_q;
   always_ff @(posedge mclk) begin
      if (rst) begin
         sw_dev_s1_q <= 1'b0;
         sw_dev_q <= 1'b0;
         csn_prev_q <= 1'b1;
         sclk_prev_q <= 1'b0;
      end else begin
         sw_dev_s1_q <= sw_dev_pin;
         sw_dev_q <= sw_dev_s1_q;
         csn_prev_q <= csn_s;
         sclk_prev_q <= sclk_s;
      end
   end

   // Frame capture: MSB first on rising link clock while select is low.
   logic [15:0] shift_q;
   logic [4:0] bits_q;
   wire sclk_rise = sclk_s && !sclk_prev_q && !csn_s;
   wire csn_fall = !csn_s && csn_prev_q;
   wire csn_rise = csn_s && !csn_prev_q;
   always_ff @(posedge mclk) begin
      if (rst) begin
         shift_q <= 16'h0000;
         bits_q <= 5'h00;
      end else if (csn_fall) begin
         bits_q <= 5'h00;
      end else if (sclk_rise) begin
         shift_q <= {shift_q[14:0], sdi_s};
         if (bits_q != 5'h1f) begin
            bits_q <= bits_q + 5'h01;
         end
      end
   end
   // A short or long frame is dropped whole, so a glitch on select cannot fake a trigger.
   wire acc = csn_rise && (bits_q == `SWW_FRAME_BITS);
   sww_frame_t fr;
   assign fr = sww_frame_t'(shift_q);

   // Core state.
   sww_state_t state_q, state_d;
   sww_cfg_t cfg_q;
   logic ref_q;
   logic [10:0] ms_q;
   logic [31:0] cyc_q;
   logic inh_arm_q, cw_pend_q;
   logic bad_q, rst_stat_q, mask_q;
   logic [1:0] cause_q;
   logic [2:0] fallback_q;

   wire off_mode = (sbc_mode == SWW_M_SLEEP) || (sbc_mode == SWW_M_FAILSAFE)
      || (sbc_mode == SWW_M_RESTART);
   wire low_mode = (sbc_mode == SWW_M_STOP) || (sbc_mode == SWW_M_FLASH);
   wire running = (state_q == SWW_RUN);
   wire ref_sel = (fr.sel == SWW_S_NORMAL) || (fr.sel == SWW_S_STOP)
      || (fr.sel == SWW_S_FLASH) || (fr.sel == SWW_S_CONFIG)
      || (fr.sel == SWW_S_READONLY);
   wire toggle = acc && ref_sel && (fr.refresh != ref_q);
   wire [10:0] period = `SWW_BASE_MS << cfg_q.code;
   wire [10:0] half = period >> 1;
   wire in_closed = cfg_q.window && (ms_q < half);
   wire expired = ms_q >= period;
   wire good_trig = running && toggle && !in_closed && !expired;
   wire bad_trig = running && toggle && in_closed;
   wire cw_miss = running && (sbc_mode == SWW_M_STOP) && cyclic_wake && cw_pend_q;
   wire fail = running && (bad_trig || expired || cw_miss);
   wire cfg_req = acc && (fr.sel == SWW_S_CONFIG);
   wire cfg_ok = fr.cfg.code <= `SWW_CODE_MAX;
   // Settings change in init freely, in normal only together with a good trigger.
   wire cfg_slot = (state_q == SWW_IDLE)
      || (good_trig && (sbc_mode == SWW_M_NORMAL));
   wire cfg_wr = cfg_req && cfg_slot && cfg_ok;
   wire cfg_bad = cfg_req && cfg_slot && !cfg_ok;
   wire inh_req = acc && (fr.sel == SWW_S_INHIBIT);
   wire inh_a = inh_req && running && low_mode && (fr.key == `SWW_INH_KEY_A);
   wire inh_b = inh_req && running && low_mode && inh_arm_q && (fr.key == `SWW_INH_KEY_B);
   wire inh_bad = inh_req && !inh_a && !inh_b;
   wire enter_run = (state_q != SWW_RUN) && (state_q != SWW_FAIL)
      && (state_q != SWW_OFF || !off_mode) && (sbc_mode == SWW_M_NORMAL);
   wire ms_clr = !running || good_trig || (fail && sw_dev_s) || enter_run;
   wire tick = (cyc_q == 32'(TICK_CYC - 1));

   always_comb begin
      state_d = state_q;
      case (state_q)
         SWW_OFF: begin
            if (sbc_mode == SWW_M_INIT) begin
               state_d = SWW_IDLE;
            end else if (sbc_mode == SWW_M_NORMAL) begin
               state_d = SWW_RUN;
            end
         end
         SWW_IDLE: begin
            if (off_mode) begin
               state_d = SWW_OFF;
            end else if (sbc_mode == SWW_M_NORMAL) begin
               state_d = SWW_RUN;
            end
         end
         SWW_RUN: begin
            if (off_mode) begin
               state_d = SWW_OFF;
            end else if (fail && !sw_dev_s) begin
               state_d = SWW_FAIL;
            end else if (inh_b) begin
               state_d = SWW_INHIB;
            end
         end
         SWW_INHIB: begin
            if (off_mode) begin
               state_d = SWW_OFF;
            end else if (sbc_mode == SWW_M_NORMAL) begin
               state_d = SWW_RUN;
            end
         end
         SWW_FAIL: begin
            if (off_mode || sbc_mode == SWW_M_INIT) begin
               state_d = SWW_OFF;
            end
         end
         default: state_d = SWW_OFF;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= SWW_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // Configuration; only the default survives the off modes.
   always_ff @(posedge mclk) begin
      if (rst || off_mode || state_q == SWW_FAIL) begin
         cfg_q <= CFG_DEF;
      end else if (cfg_wr && !low_mode) begin
         cfg_q <= fr.cfg;
      end
   end

   // Refresh bit mirror; cleared whenever the watchdog is off or has failed.
   always_ff @(posedge mclk) begin
      if (rst || state_q == SWW_OFF || state_q == SWW_FAIL) begin
         ref_q <= 1'b0;
      end else if (acc && ref_sel) begin
         ref_q <= fr.refresh;
      end
   end

   // Millisecond timebase.
   always_ff @(posedge mclk) begin
      if (rst || ms_clr) begin
         cyc_q <= 32'h0000_0000;
         ms_q <= 11'h000;
      end else if (tick) begin
         cyc_q <= 32'h0000_0000;
         if (!expired) begin
            ms_q <= ms_q + 11'h001;
         end
      end else begin
         cyc_q <= cyc_q + 32'h0000_0001;
      end
   end

   // Inhibit arming: key A must be the frame directly before key B.
   always_ff @(posedge mclk) begin
      if (rst) begin
         inh_arm_q <= 1'b0;
      end else if (acc) begin
         inh_arm_q <= inh_a;
      end
   end

   // Cyclic wake acknowledge; a new wake wins over a same-cycle read.
   always_ff @(posedge mclk) begin
      if (rst || !running || sbc_mode != SWW_M_STOP) begin
         cw_pend_q <= 1'b0;
      end else if (cyclic_wake) begin
         cw_pend_q <= 1'b1;
      end else if (wake_status_read) begin
         cw_pend_q <= 1'b0;
      end
   end

   // Failure outputs.
   always_ff @(posedge mclk) begin
      if (rst) begin
         reset_output_pin_n <= 1'b1;
         wd_fail_pulse <= 1'b0;
         fail_to_restart <= 1'b0;
      end else begin
         reset_output_pin_n <= (state_d != SWW_FAIL);
         wd_fail_pulse <= fail && !sw_dev_s;
         if (fail && !sw_dev_s) begin
            fail_to_restart <= cfg_restart || cw_miss;
         end
      end
   end

   // Status flags; hardware set wins over a clearing status read.
   wire stat_rd = rd && (addr == `SWW_OFF_STATUS);
   wire set_bad = cfg_bad || inh_bad;
   wire set_rst_stat = fail && sw_dev_s;
   always_ff @(posedge mclk) begin
      if (rst) begin
         bad_q <= 1'b0;
         rst_stat_q <= 1'b0;
         cause_q <= 2'h0;
         fallback_q <= 3'h0;
         int_pulse <= 1'b0;
      end else begin
         bad_q <= set_bad || (bad_q && !stat_rd);
         rst_stat_q <= set_rst_stat || (rst_stat_q && !stat_rd);
         if (fail && !sw_dev_s) begin
            cause_q <= `SWW_CAUSE_WD;
            fallback_q <= `SWW_FALLBACK_WD;
         end
         int_pulse <= set_rst_stat || (set_bad && mask_q);
      end
   end

   // Register port: status reads clear event flags, the mask gates the setting interrupt.
   always_ff @(posedge mclk) begin
      if (rst) begin
         mask_q <= `SWW_MASK_RESET;
      end else if (wr && addr == `SWW_OFF_MASK) begin
         mask_q <= wdata[0];
      end
   end
   wire [31:0] rd_status = {25'h0, bad_q, rst_stat_q, cause_q, fallback_q};
   wire [31:0] rd_config = {24'h0, state_q, cfg_q, ref_q};
   wire [31:0] rd_mask = {31'h0, mask_q};
   wire [31:0] rd_mux = (addr == `SWW_OFF_STATUS) ? rd_status
      : (addr == `SWW_OFF_CONFIG) ? rd_config
      : (addr == `SWW_OFF_MASK) ? rd_mask : 32'h0000_0000;
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         rdata <= rd_mux;
      end
   end

   // Checks on the design's own behaviour.
   a_fail_reset_low: assert property (@(posedge mclk) disable iff (rst)
      fail && !sw_dev_s |=> !reset_output_pin_n && wd_fail_pulse)
      else $error("failure did not pull reset low");
   a_dev_no_reset: assert property (@(posedge mclk) disable iff (rst)
      fail && sw_dev_s |=> reset_output_pin_n && rst_stat_q && int_pulse)
      else $error("development mode failure handled wrongly");
   a_refresh_cleared: assert property (@(posedge mclk) disable iff (rst)
      state_q == SWW_OFF ##1 state_q == SWW_OFF |-> !ref_q)
      else $error("refresh bit not cleared while off");
   a_off_default_cfg: assert property (@(posedge mclk) disable iff (rst)
      off_mode |=> cfg_q == CFG_DEF)
      else $error("configuration kept through an off mode");
   a_trig_restarts: assert property (@(posedge mclk) disable iff (rst)
      good_trig |=> ms_q == 11'h000 && state_q == SWW_RUN)
      else $error("accepted trigger did not restart timer");
   a_closed_window: assert property (@(posedge mclk) disable iff (rst)
      bad_trig && !sw_dev_s |=> state_q == SWW_FAIL)
      else $error("closed window trigger not punished");
   a_bad_cfg_kept: assert property (@(posedge mclk) disable iff (rst)
      cfg_bad && !off_mode |=> cfg_q == $past(cfg_q) && bad_q)
      else $error("invalid setting accepted");
   a_stop_fixed: assert property (@(posedge mclk) disable iff (rst)
      low_mode && $past(low_mode) |-> $stable(cfg_q))
      else $error("setting changed in stop or flash");
   a_init_idle: assert property (@(posedge mclk) disable iff (rst)
      sbc_mode == SWW_M_INIT && state_q == SWW_IDLE |=> ms_q == 11'h000)
      else $error("watchdog ran in init");
   a_inhibit_resume: assert property (@(posedge mclk) disable iff (rst)
      state_q == SWW_INHIB && sbc_mode == SWW_M_NORMAL
      |=> state_q == SWW_RUN ##1 ms_q == 11'h000 && cfg_q == $past(cfg_q, 2))
      else $error("resume from inhibit wrong");
   a_wake_ack_miss: assert property (@(posedge mclk) disable iff (rst)
      cw_miss && !sw_dev_s |=> fail_to_restart && !reset_output_pin_n)
      else $error("unacknowledged cyclic wake not forced to restart");
endmodule : sww_watchdog

/* test/sww_host_model.sv */
// Host model that serves the watchdog with 16-bit serial frames.
`timescale 1ns/1ps
module sww_host_model (
   output logic serial_select_low,
   output logic serial_clk,
   output logic serial_data_in
);
   import sww_pkg::*;
   initial begin
      serial_select_low = 1'b1;
      serial_clk = 1'b0;
      serial_data_in = 1'b0;
   end
   // The link clock stays low between frames.
   // Data is inverted after release so a stale bit is never read as fresh.
   task automatic send(input sww_frame_t f);
      #3;
      serial_select_low = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         serial_data_in = f[i];
         #80;
         serial_clk = 1'b1;
         #80;
         serial_clk = 1'b0;
      end
      #40;
      serial_select_low = 1'b1;
      serial_data_in = ~f[0];
   endtask : send
endmodule : sww_host_model

/* test/sww_watchdog_tb.sv */
// Self-checking bench for the serial watchdog with a host model on its serial side.
`timescale 1ns/1ps
`include "sww_params.svh"
module sww_watchdog_tb;
   import sww_pkg::*;
   // One millisecond is shortened to 100 cycles so the long windows fit the run.
   localparam int TICK = 100;
   localparam int FRAME_CYC = 264;
   localparam int LIMIT = 60000;
   localparam logic [2:0] SELS [4] = '{SWW_S_NORMAL, SWW_S_STOP, SWW_S_FLASH, SWW_S_READONLY};
   typedef struct {logic [3:0] a; logic w; logic [31:0] v; logic [31:0] e;} sww_row_t;
   sww_row_t rows [5] = '{'{4'h0, 1'b0, 32'h0, 32'h0}, '{4'h4, 1'b1, 32'hff, 32'h8},
      '{4'hc, 1'b1, 32'hff, 32'h0}, '{4'h8, 1'b1, 32'h0, 32'h0}, '{4'h8, 1'b1, 32'h1, 32'h1}};
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic sw_dev_pin = 1'b0;
   sww_mode_t sbc_mode = SWW_M_SLEEP;
   logic cfg_restart = 1'b1;
   logic cyclic_wake = 1'b0;
   logic wake_status_read = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata, rd_val;
   logic reset_output_pin_n, wd_fail_pulse, fail_to_restart, int_pulse;
   logic serial_select_low, serial_clk, serial_data_in;
   logic r;
   int error_cnt = 0;
   int compares = 0;
   int n_int = 0;
   int n_fail = 0;
   int cyc = 0;
   int k;

   sww_watchdog #(.TICK_CYC(TICK)) u_dut (.mclk(mclk), .rst(rst),
      .serial_select_low(serial_select_low), .serial_clk(serial_clk),
      .serial_data_in(serial_data_in), .sw_dev_pin(sw_dev_pin), .sbc_mode(sbc_mode),
      .cfg_restart(cfg_restart), .cyclic_wake(cyclic_wake),
      .wake_status_read(wake_status_read), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .reset_output_pin_n(reset_output_pin_n), .wd_fail_pulse(wd_fail_pulse),
      .fail_to_restart(fail_to_restart), .int_pulse(int_pulse));
   sww_host_model u_host (.serial_select_low(serial_select_low), .serial_clk(serial_clk),
      .serial_data_in(serial_data_in));

   always #5 mclk = ~mclk;

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (int_pulse === 1'b1) n_int <= n_int + 1;
      if (wd_fail_pulse === 1'b1) n_fail <= n_fail + 1;
      if (cyc == LIMIT) begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic cycles(input int n);
      repeat (n) @(posedge mclk);
   endtask : cycles

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      rd_val = rdata;
      @(posedge mclk);
   endtask : reg_rd

   task automatic pin(input logic e);
      @(negedge mclk);
      check(32'(reset_output_pin_n), 32'(e));
      @(posedge mclk);
   endtask : pin

   // The wait is trimmed by the frame length so that ms counts select rise to select rise.
   task automatic tx(input int ms, input sww_frame_t f);
      cycles(ms * TICK - FRAME_CYC);
      u_host.send(f);
      cycles(6);
   endtask : tx

   task automatic pulse(input logic wake);
      if (wake) cyclic_wake <= 1'b1;
      else wake_status_read <= 1'b1;
      @(posedge mclk);
      cyclic_wake <= 1'b0;
      wake_status_read <= 1'b0;
      cycles(5);
   endtask : pulse

   task automatic reboot();
      sbc_mode <= SWW_M_RESTART;
      cycles(3);
      sbc_mode <= SWW_M_NORMAL;
      cycles(3);
   endtask : reboot

   function automatic sww_frame_t fr(input logic [2:0] s, input logic b, input logic [3:0] c,
      input logic [7:0] key);
      fr = {s, b, c, key};
   endfunction : fr

   task automatic complete_run();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      cycles(16);
      rst <= 1'b0;
      cycles(4);
      foreach (rows[i]) begin
         if (rows[i].w) reg_wr(rows[i].a, rows[i].v);
         reg_rd(rows[i].a);
         check(rd_val, rows[i].e);
      end
      pin(1'b1);
      $display("test registers done");
      sbc_mode <= SWW_M_NORMAL;
      r = 1'b1;
      tx(150, fr(SWW_S_CONFIG, r, 4'h0, 8'h0));
      reg_rd(4'h4);
      check(rd_val, 32'h41);
      foreach (SELS[i]) begin
         r = ~r;
         tx(12, fr(SELS[i], r, 4'h0, 8'h0));
         reg_rd(4'h4);
         check(rd_val, 32'h40 | 32'(r));
      end
      // A frame that repeats the refresh bit must not restart the period.
      tx(8, fr(SWW_S_NORMAL, r, 4'h0, 8'h0));
      cycles(6 * TICK);
      pin(1'b1);
      cycles(3 * TICK);
      pin(1'b0);
      check(32'(n_fail), 32'h1);
      check(32'(fail_to_restart), 32'h1);
      reg_rd(4'h0);
      check(rd_val, 32'h9);
      reboot();
      pin(1'b1);
      reg_rd(4'h4);
      check(rd_val, 32'h48);
      $display("test time-out done");
      r = 1'b1;
      tx(5, fr(SWW_S_CONFIG, r, 4'h9, 8'h0));
      r = ~r;
      tx(20, fr(SWW_S_READONLY, r, 4'h0, 8'h0));
      r = ~r;
      tx(20, fr(SWW_S_NORMAL, r, 4'h0, 8'h0));
      pin(1'b1);
      k = n_int;
      r = ~r;
      tx(20, fr(SWW_S_CONFIG, r, 4'hf, 8'h0));
      reg_rd(4'h4);
      check(32'(rd_val[4:0]), 32'({4'h9, r}));
      reg_rd(4'h0);
      check(32'(rd_val[6]), 32'h1);
      check(32'(n_int - k), 32'h1);
      sw_dev_pin <= 1'b1;
      k = n_int;
      r = ~r;
      tx(8, fr(SWW_S_NORMAL, r, 4'h0, 8'h0));
      cycles(4);
      pin(1'b1);
      check(32'(n_int - k), 32'h1);
      reg_rd(4'h0);
      check(32'(rd_val[5]), 32'h1);
      sw_dev_pin <= 1'b0;
      reboot();
      $display("test window done");
      r = 1'b1;
      tx(5, fr(SWW_S_CONFIG, r, 4'h9, 8'h0));
      sbc_mode <= SWW_M_STOP;
      r = ~r;
      tx(20, fr(SWW_S_CONFIG, r, 4'h2, 8'h0));
      reg_rd(4'h4);
      check(32'(rd_val[4:0]), 32'({4'h9, r}));
      tx(3, fr(SWW_S_INHIBIT, r, 4'h9, `SWW_INH_KEY_B));
      reg_rd(4'h0);
      check(32'(rd_val[6]), 32'h1);
      tx(3, fr(SWW_S_INHIBIT, r, 4'h9, `SWW_INH_KEY_A));
      tx(3, fr(SWW_S_INHIBIT, r, 4'h9, `SWW_INH_KEY_B));
      reg_rd(4'h4);
      check(32'(rd_val[7:5]), 32'h3);
      cycles(40 * TICK);
      pin(1'b1);
      sbc_mode <= SWW_M_NORMAL;
      reg_rd(4'h4);
      check(32'(rd_val[7:0]), 32'({3'h2, 4'h9, r}));
      r = ~r;
      tx(8, fr(SWW_S_NORMAL, r, 4'h0, 8'h0));
      cycles(4);
      pin(1'b0);
      reboot();
      $display("test inhibit done");
      cfg_restart <= 1'b0;
      sbc_mode <= SWW_M_STOP;
      pulse(1'b1);
      pulse(1'b0);
      pulse(1'b1);
      pin(1'b1);
      pulse(1'b1);
      cycles(4);
      pin(1'b0);
      check(32'(fail_to_restart), 32'h1);
      $display("test cyclic wake done");
      sbc_mode <= SWW_M_INIT;
      tx(3, fr(SWW_S_CONFIG, 1'b1, 4'h9, 8'h0));
      reg_rd(4'h4);
      check(rd_val, 32'h33);
      pin(1'b1);
      $display("test init done");
      complete_run();
   end
endmodule : sww_watchdog_tb
